// [verilog/pesr_pkg.sv]
package pesr_pkg;

  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_WIDTH = 12;
  localparam int unsigned DATA_WIDTH = 32;
  localparam int unsigned REG_WIDTH  = 16;

  // Register indices and their word byte addresses
  localparam logic [ADDR_WIDTH-1:0] IDX_ADVERT  = 12'h0EC;
  localparam logic [ADDR_WIDTH-1:0] IDX_WAKEERR = 12'h0EE;
  localparam logic [ADDR_WIDTH-1:0] IDX_CTRLSTS = 12'h0F0;
  localparam logic [ADDR_WIDTH-1:0] ADDR_ADVERT  = 12'(IDX_ADVERT * 4);
  localparam logic [ADDR_WIDTH-1:0] ADDR_WAKEERR = 12'(IDX_WAKEERR * 4);
  localparam logic [ADDR_WIDTH-1:0] ADDR_CTRLSTS = 12'(IDX_CTRLSTS * 4);

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int unsigned LP_CAP_WIDTH  = 6;
  localparam int unsigned ADV_LP_MSB    = 14;
  localparam int unsigned ADV_LP_LSB    = 9;
  localparam int unsigned ADV_LOC_MSB   = 6;
  localparam int unsigned ADV_LOC_LSB   = 2;
  localparam int unsigned ADV_TX100_BIT = 1;
  localparam int unsigned CS_RSV_BIT    = 15;
  localparam int unsigned CS_HWEN_BIT   = 14;
  localparam int unsigned CS_TXSEEN_BIT = 13;
  localparam int unsigned CS_TXLIVE_BIT = 12;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic                 ADV_TX100_RESET = 1'b1;
  localparam logic                 CS_RSV_RESET    = 1'b1;
  localparam logic [REG_WIDTH-1:0] WAKEERR_RESET   = 16'h0000;
  localparam logic [REG_WIDTH-1:0] WAKEERR_MAX     = 16'hFFFF;
  localparam logic [REG_WIDTH-1:0] WAKEERR_STEP    = 16'h0001;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS    = 4000;
  localparam int unsigned WAKE_LIMIT_PS    = 20500000;
  localparam int unsigned WAKE_LIMIT_CYC   =
    (WAKE_LIMIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WAKE_CNT_WIDTH   = 16;
  localparam logic [WAKE_CNT_WIDTH-1:0] WAKE_CNT_ZERO = 16'h0000;
  localparam logic [WAKE_CNT_WIDTH-1:0] WAKE_CNT_STEP = 16'h0001;

  typedef enum logic [1:0] {
    WAKE_IDLE   = 2'b00,
    WAKE_TIMING = 2'b01,
    WAKE_LATE   = 2'b10
  } pesr_wake_state_type;

endpackage

// [verilog/pesr_wake_counter.sv]
module pesr_wake_counter
  import pesr_pkg::*;
(
  input  wire  logic                 ref_clk,
  input  wire  logic                 resetn,
  input  wire  logic                 countEnable,
  input  wire  logic                 timerDone,
  input  wire  logic                 clearPulse,
  output logic       [REG_WIDTH-1:0] count
);

  logic prevDone;
  logic bump;

  // ----------------------------------------------------------------
  // Wake error counting
  // ----------------------------------------------------------------
  assign bump = countEnable && timerDone && !prevDone;

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      prevDone <= 1'b0;
    else
      prevDone <= timerDone;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      count <= WAKEERR_RESET;
    else if (clearPulse)
      count <= bump ? WAKEERR_STEP : WAKEERR_RESET;
    else if (bump && count != WAKEERR_MAX)
      count <= count + WAKEERR_STEP;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  AST_WEC_INC: assert property (
    bump && !clearPulse && count != WAKEERR_MAX |=> count == $past(count) + WAKEERR_STEP)
    else $error("wake error count did not step");
  AST_WEC_SAT: assert property (
    count == WAKEERR_MAX && !clearPulse |=> count == WAKEERR_MAX)
    else $error("wake error count wrapped");
  AST_WEC_CLEAR: assert property (
    clearPulse && !bump |=> count == WAKEERR_RESET)
    else $error("wake error count not cleared by read");
  AST_WEC_KEEP: assert property (
    clearPulse && bump |=> count == WAKEERR_STEP)
    else $error("error lost during clearing read");

endmodule

// [verilog/pesr_regs.sv]
// Operation
// - Link partner EEE abilities appear read-only in bits 14..9, reset zero.
// - Local 10G/1G advertisement bits 6..2 are read-only and read zero.
// - Local 100BASE-TX advertisement bit 1 is read/write, reset one.
// - In fiber mode advertisement, wake counting and LPI status stay inactive.
// - Wake error counter steps on each rising edge of wake timer done.
// - A wake taking longer than 20.5 us counts as a wake error.
// - The wake error counter saturates at all ones.
// - Reading the wake error counter returns it, then clears it.
// - Status bit 14 shows hardware next-page 100BASE-TX EEE enable.
// - Status bit 13 latches high on any transmit LPI signaling.
// - Bit 13 clears only on a host write of one.
// - Status bit 12 shows live transmit LPI state.
//
// The AXI4-Lite interface to the registers was left to the implementer.
module pesr_regs
  import pesr_pkg::*;
#(
  parameter int unsigned WAKE_LIMIT_CYCLES = WAKE_LIMIT_CYC
)
(
  input  wire  logic                    ref_clk,
  input  wire  logic                    resetn,
  input  wire  logic [ADDR_WIDTH-1:0]   s_axi_awaddr,
  input  wire  logic                    s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire  logic [DATA_WIDTH-1:0]   s_axi_wdata,
  input  wire  logic [DATA_WIDTH/8-1:0] s_axi_wstrb,
  input  wire  logic                    s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire  logic                    s_axi_bready,
  input  wire  logic [ADDR_WIDTH-1:0]   s_axi_araddr,
  input  wire  logic                    s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [DATA_WIDTH-1:0]         s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire  logic                    s_axi_rready,
  input  wire  logic                    fiberMode,
  input  wire  logic [LP_CAP_WIDTH-1:0] lpEeeCap,
  input  wire  logic                    hwEee100Enabled,
  input  wire  logic                    txLpiActive,
  input  wire  logic                    wakeStart,
  input  wire  logic                    wakeDone,
  output logic                          eeeAdvertise100
);

  localparam logic [WAKE_CNT_WIDTH-1:0] WAKE_LAST =
    WAKE_CNT_WIDTH'(WAKE_LIMIT_CYCLES - 1);

  logic [ADDR_WIDTH-1:0]   wrAddr;
  logic [DATA_WIDTH-1:0]   wrData;
  logic [DATA_WIDTH/8-1:0] wrStrb;
  logic                    doWrite;
  logic                    wrHit;
  logic                    arTake;
  logic [DATA_WIDTH-1:0]   readData;
  logic                    readHit;
  logic                    readClear;
  logic                    eeeOn;
  logic                    advTx100;
  logic                    csReserved;
  logic                    txLpiSeen;
  logic                    txLpiEvent;
  logic                    txSeenClear;
  logic [REG_WIDTH-1:0]    wakeErrCount;
  logic                    timerDone;
  logic [WAKE_CNT_WIDTH-1:0] wakeCnt;
  pesr_wake_state_type     wakeState;
  pesr_wake_state_type     next_wakeState;

  assign eeeOn = !fiberMode;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      s_axi_awready <= 1'b1;
    else if (s_axi_awvalid && s_axi_awready)
      s_axi_awready <= 1'b0;
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_awready <= 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      s_axi_wready <= 1'b1;
    else if (s_axi_wvalid && s_axi_wready)
      s_axi_wready <= 1'b0;
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_wready <= 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      wrAddr <= '0;
    else if (s_axi_awvalid && s_axi_awready)
      wrAddr <= s_axi_awaddr;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      wrData <= '0;
      wrStrb <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      wrData <= s_axi_wdata;
      wrStrb <= s_axi_wstrb;
    end
  end

  always_comb
  begin
    if (wrAddr == ADDR_ADVERT)
      wrHit = 1'b1;
    else if (wrAddr == ADDR_WAKEERR)
      wrHit = 1'b1;
    else if (wrAddr == ADDR_CTRLSTS)
      wrHit = 1'b1;
    else
      wrHit = 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (doWrite)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Writable bits
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      advTx100 <= ADV_TX100_RESET;
    else if (doWrite && wrAddr == ADDR_ADVERT && wrStrb[0])
      advTx100 <= wrData[ADV_TX100_BIT];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      csReserved <= CS_RSV_RESET;
    else if (doWrite && wrAddr == ADDR_CTRLSTS && wrStrb[1])
      csReserved <= wrData[CS_RSV_BIT];
  end

  // Advertisement toward negotiation, silenced in fiber mode
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      eeeAdvertise100 <= 1'b0;
    else
      eeeAdvertise100 <= advTx100 && eeeOn;
  end

  // ----------------------------------------------------------------
  // Transmit LPI latch
  // ----------------------------------------------------------------
  assign txLpiEvent  = txLpiActive && eeeOn;
  assign txSeenClear = doWrite && wrAddr == ADDR_CTRLSTS && wrStrb[1]
                       && wrData[CS_TXSEEN_BIT];

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      txLpiSeen <= 1'b0;
    else if (txLpiEvent)
      txLpiSeen <= 1'b1;
    else if (txSeenClear)
      txLpiSeen <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Wake timer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_wakeState = wakeState;
    case (wakeState)
      WAKE_IDLE:
        if (wakeStart && eeeOn)
          next_wakeState = WAKE_TIMING;
      WAKE_TIMING:
        if (!eeeOn || wakeDone)
          next_wakeState = WAKE_IDLE;
        else if (wakeCnt == WAKE_LAST)
          next_wakeState = WAKE_LATE;
      WAKE_LATE:
        if (!eeeOn || wakeDone)
          next_wakeState = WAKE_IDLE;
      default:
        next_wakeState = WAKE_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      wakeState <= WAKE_IDLE;
    else
      wakeState <= next_wakeState;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      wakeCnt <= WAKE_CNT_ZERO;
    else if (wakeState != WAKE_TIMING)
      wakeCnt <= WAKE_CNT_ZERO;
    else if (wakeCnt != WAKE_LAST)
      wakeCnt <= wakeCnt + WAKE_CNT_STEP;
  end

  assign timerDone = wakeState == WAKE_LATE;

  pesr_wake_counter u_wake_counter (
    .ref_clk     (ref_clk),
    .resetn      (resetn),
    .countEnable (eeeOn),
    .timerDone   (timerDone),
    .clearPulse  (readClear),
    .count       (wakeErrCount)
  );

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign arTake    = s_axi_arvalid && s_axi_arready;
  assign readClear = arTake && s_axi_araddr == ADDR_WAKEERR;

  always_comb
  begin
    readData = '0;
    readHit  = 1'b1;
    if (s_axi_araddr == ADDR_ADVERT)
    begin
      readData[ADV_LP_MSB:ADV_LP_LSB] = eeeOn ? lpEeeCap : '0;
      readData[ADV_TX100_BIT]         = advTx100;
    end
    else if (s_axi_araddr == ADDR_WAKEERR)
      readData[REG_WIDTH-1:0] = wakeErrCount;
    else if (s_axi_araddr == ADDR_CTRLSTS)
    begin
      readData[CS_RSV_BIT]    = csReserved;
      readData[CS_HWEN_BIT]   = hwEee100Enabled && eeeOn;
      readData[CS_TXSEEN_BIT] = txLpiSeen;
      readData[CS_TXLIVE_BIT] = txLpiEvent;
    end
    else
      readHit = 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      s_axi_arready <= 1'b1;
    else if (arTake)
      s_axi_arready <= 1'b0;
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_arready <= 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (arTake)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= readData;
      s_axi_rresp  <= readHit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence advRead;
    arTake && s_axi_araddr == ADDR_ADVERT;
  endsequence

  sequence csRead;
    arTake && s_axi_araddr == ADDR_CTRLSTS;
  endsequence

  sequence bothTaken;
    !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  endsequence

  AST_LP_CAP: assert property (
    advRead |=> s_axi_rvalid
      && s_axi_rdata[ADV_LP_MSB:ADV_LP_LSB] == ($past(fiberMode) ? '0 : $past(lpEeeCap)))
    else $error("partner ability bits wrong");
  AST_LOCAL_ZERO: assert property (
    advRead |=> s_axi_rdata[ADV_LOC_MSB:ADV_LOC_LSB] == '0)
    else $error("unsupported local bits not zero");
  AST_ADV_WRITE: assert property (
    bothTaken ##0 (wrAddr == ADDR_ADVERT && wrStrb[0])
      |=> advTx100 == $past(wrData[ADV_TX100_BIT])
      ##1 eeeAdvertise100 == ($past(advTx100) && !$past(fiberMode)))
    else $error("advertisement bit not written");
  AST_FIBER_QUIET: assert property (
    fiberMode [*2] |-> !eeeAdvertise100 && wakeState == WAKE_IDLE)
    else $error("EEE active in fiber mode");
  AST_WAKE_LATE: assert property (
    wakeState == WAKE_TIMING && wakeCnt == WAKE_LAST && eeeOn && !wakeDone |=> timerDone)
    else $error("late wake not flagged");
  AST_WAKE_EARLY: assert property (
    $rose(timerDone) |-> wakeCnt == WAKE_LAST && $past(wakeState) == WAKE_TIMING)
    else $error("wake flagged before limit");
  AST_HW_EN: assert property (
    csRead |=> s_axi_rdata[CS_HWEN_BIT] == ($past(hwEee100Enabled) && !$past(fiberMode)))
    else $error("hardware enable status wrong");
  AST_TX_LATCH: assert property (
    txLpiEvent |=> txLpiSeen [*1] ##1 (txLpiSeen || $past(txSeenClear)))
    else $error("transmit LPI not latched");
  AST_TX_W1C: assert property (
    txLpiSeen && !txLpiEvent && !txSeenClear |=> txLpiSeen)
    else $error("latched LPI cleared without write of one");
  AST_TX_CLR: assert property (
    txSeenClear && !txLpiEvent |=> !txLpiSeen)
    else $error("write of one did not clear LPI latch");
  AST_TX_LIVE: assert property (
    csRead |=> s_axi_rdata[CS_TXLIVE_BIT] == ($past(txLpiActive) && !$past(fiberMode)))
    else $error("live transmit LPI bit wrong");

endmodule

// [tb/tb.sv]
module tb
  import pesr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned LIM = 12;

  logic                    ref_clk;
  logic                    resetn;
  logic [ADDR_WIDTH-1:0]   s_axi_awaddr;
  logic                    s_axi_awvalid;
  logic                    s_axi_awready;
  logic [DATA_WIDTH-1:0]   s_axi_wdata;
  logic [DATA_WIDTH/8-1:0] s_axi_wstrb;
  logic                    s_axi_wvalid;
  logic                    s_axi_wready;
  logic [1:0]              s_axi_bresp;
  logic                    s_axi_bvalid;
  logic                    s_axi_bready;
  logic [ADDR_WIDTH-1:0]   s_axi_araddr;
  logic                    s_axi_arvalid;
  logic                    s_axi_arready;
  logic [DATA_WIDTH-1:0]   s_axi_rdata;
  logic [1:0]              s_axi_rresp;
  logic                    s_axi_rvalid;
  logic                    s_axi_rready;
  logic                    fiberMode;
  logic [LP_CAP_WIDTH-1:0] lpEeeCap;
  logic                    hwEee100Enabled;
  logic                    txLpiActive;
  logic                    wakeStart;
  logic                    wakeDone;
  logic                    eeeAdvertise100;
  int                      failures;
  int                      samples_checked;

  pesr_regs #(.WAKE_LIMIT_CYCLES(LIM)) i_pesr_regs (.*);

  always #2 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %b expected %b", $time, msg, got, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er,
                    input logic [3:0] s = 4'hF);
    bit awDone;
    bit wDone;
    awDone = 0;
    wDone = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {16'h0000, d};
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever
    begin
      @(posedge ref_clk);
      if (s_axi_bvalid)
      begin
        chk_resp(s_axi_bresp, er, "write response");
        s_axi_bready <= 1'b0;
        break;
      end
      if (!awDone && s_axi_awready)
      begin
        awDone = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wDone && s_axi_wready)
      begin
        wDone = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    bit arDone;
    arDone = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever
    begin
      @(posedge ref_clk);
      if (s_axi_rvalid)
      begin
        chk(s_axi_rdata, e, "read data");
        chk_resp(s_axi_rresp, er, "read response");
        s_axi_rready <= 1'b0;
        break;
      end
      if (!arDone && s_axi_arready)
      begin
        arDone = 1;
        s_axi_arvalid <= 1'b0;
      end
    end
    @(posedge ref_clk);
  endtask

  task automatic late_wake();
    wakeStart <= 1'b1;
    cycles(1);
    wakeStart <= 1'b0;
    cycles(LIM + 6);
    wakeDone <= 1'b1;
    cycles(1);
    wakeDone <= 1'b0;
    cycles(2);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    rd(ADDR_ADVERT, 32'h0000_0002, RESP_OKAY);
    rd(ADDR_WAKEERR, 32'h0000_0000, RESP_OKAY);
    rd(ADDR_CTRLSTS, 32'h0000_8000, RESP_OKAY);
    chk_bit(eeeAdvertise100, 1'b1, "advertise out");
  endtask

  task automatic test_advert();
    lpEeeCap <= 6'h2A;
    cycles(2);
    rd(ADDR_ADVERT, 32'h0000_5402, RESP_OKAY);
    wr(ADDR_ADVERT, 16'hFFFF, RESP_OKAY);
    rd(ADDR_ADVERT, 32'h0000_5402, RESP_OKAY);
    // Clearing the advertisement only; EEE itself is turned off elsewhere
    wr(ADDR_ADVERT, 16'h0000, RESP_OKAY);
    lpEeeCap <= 6'h15;
    cycles(2);
    rd(ADDR_ADVERT, 32'h0000_2A00, RESP_OKAY);
    chk_bit(eeeAdvertise100, 1'b0, "advertise off");
    wr(ADDR_ADVERT, 16'h0002, RESP_OKAY);
    rd(ADDR_ADVERT, 32'h0000_2A02, RESP_OKAY);
  endtask

  task automatic test_status();
    hwEee100Enabled <= 1'b1;
    txLpiActive     <= 1'b1;
    cycles(2);
    rd(ADDR_CTRLSTS, 32'h0000_F000, RESP_OKAY);
    txLpiActive <= 1'b0;
    cycles(2);
    rd(ADDR_CTRLSTS, 32'h0000_E000, RESP_OKAY);
    wr(ADDR_CTRLSTS, 16'h8000, RESP_OKAY);
    rd(ADDR_CTRLSTS, 32'h0000_E000, RESP_OKAY);
    wr(ADDR_CTRLSTS, 16'hA000, RESP_OKAY);
    hwEee100Enabled <= 1'b0;
    rd(ADDR_CTRLSTS, 32'h0000_8000, RESP_OKAY);
    txLpiActive <= 1'b1;
    wr(ADDR_CTRLSTS, 16'hA000, RESP_OKAY);
    rd(ADDR_CTRLSTS, 32'h0000_B000, RESP_OKAY);
    txLpiActive <= 1'b0;
    wr(ADDR_CTRLSTS, 16'hA000, RESP_OKAY);
    rd(ADDR_CTRLSTS, 32'h0000_8000, RESP_OKAY);
  endtask

  task automatic test_wake();
    late_wake();
    late_wake();
    rd(ADDR_WAKEERR, 32'h0000_0002, RESP_OKAY);
    rd(ADDR_WAKEERR, 32'h0000_0000, RESP_OKAY);
    wakeStart <= 1'b1;
    cycles(1);
    wakeStart <= 1'b0;
    cycles(LIM - 4);
    wakeDone <= 1'b1;
    cycles(1);
    wakeDone <= 1'b0;
    cycles(LIM + 4);
    rd(ADDR_WAKEERR, 32'h0000_0000, RESP_OKAY);
    wr(ADDR_WAKEERR, 16'hFFFF, RESP_OKAY);
    late_wake();
    rd(ADDR_WAKEERR, 32'h0000_0001, RESP_OKAY);
    // Late wake lands on the edge that takes the clearing read
    late_wake();
    wakeStart <= 1'b1;
    cycles(1);
    wakeStart <= 1'b0;
    cycles(LIM);
    rd(ADDR_WAKEERR, 32'h0000_0001, RESP_OKAY);
    wakeDone <= 1'b1;
    cycles(1);
    wakeDone <= 1'b0;
    rd(ADDR_WAKEERR, 32'h0000_0001, RESP_OKAY);
  endtask

  task automatic test_fiber();
    fiberMode       <= 1'b1;
    lpEeeCap        <= 6'h3F;
    hwEee100Enabled <= 1'b1;
    txLpiActive     <= 1'b1;
    cycles(3);
    chk_bit(eeeAdvertise100, 1'b0, "fiber advertise");
    rd(ADDR_ADVERT, 32'h0000_0002, RESP_OKAY);
    rd(ADDR_CTRLSTS, 32'h0000_8000, RESP_OKAY);
    late_wake();
    rd(ADDR_WAKEERR, 32'h0000_0000, RESP_OKAY);
    fiberMode       <= 1'b0;
    lpEeeCap        <= 6'h00;
    hwEee100Enabled <= 1'b0;
    txLpiActive     <= 1'b0;
    cycles(3);
    chk_bit(eeeAdvertise100, 1'b1, "copper advertise");
  endtask

  task automatic test_unmapped();
    rd(12'h000, 32'h0000_0000, RESP_SLVERR);
    wr(12'h004, 16'hFFFF, RESP_SLVERR);
    rd(12'h3B4, 32'h0000_0000, RESP_SLVERR);
    // Low byte strobe off: stored advertisement bit must stay
    wr(ADDR_ADVERT, 16'h0000, RESP_OKAY, 4'hE);
    rd(ADDR_ADVERT, 32'h0000_0002, RESP_OKAY);
  endtask

  task automatic test_midreset();
    wr(ADDR_ADVERT, 16'h0000, RESP_OKAY);
    txLpiActive <= 1'b1;
    late_wake();
    txLpiActive <= 1'b0;
    resetn <= 1'b0;
    cycles(2);
    resetn <= 1'b1;
    cycles(2);
    test_reset();
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk = 0;
    resetn = 0;
    s_axi_awaddr = '0;
    s_axi_awvalid = 0;
    s_axi_wdata = '0;
    s_axi_wstrb = '0;
    s_axi_wvalid = 0;
    s_axi_bready = 0;
    s_axi_araddr = '0;
    s_axi_arvalid = 0;
    s_axi_rready = 0;
    fiberMode = 0;
    lpEeeCap = '0;
    hwEee100Enabled = 0;
    txLpiActive = 0;
    wakeStart = 0;
    wakeDone = 0;
    failures = 0;
    samples_checked = 0;
    cycles(12);
    resetn <= 1'b1;
    cycles(2);
    test_reset();
    test_advert();
    test_status();
    test_wake();
    test_fiber();
    test_unmapped();
    test_midreset();
    finish_test();
  end

  initial
  begin
    #80000;
    failures++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule
